//--- design/ipr_reset_state_init_cfg.svh
/*
  Register map, field positions and reset values of the processor control
  register bank.
  Assumes: included by bare name from the design files; definitions only.
*/
`ifndef IPR_RESET_STATE_INIT_CFG_SVH
`define IPR_RESET_STATE_INIT_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define REG_ADDR_W       8
`define OFS_MEM_CTL      8'h00
`define OFS_BUS_INTERFACE_CONTROL      8'h04
`define OFS_IU_CTL       8'h08
`define OFS_CYC_CNT      8'h0C
`define OFS_CYC_CTL      8'h10
`define OFS_DTLB_FLUSH   8'h14
`define OFS_TLB_PSEL     8'h18
`define OFS_SERIAL_LINE_TRANSMIT      8'h1C
`define OFS_BUS_ERR_ADR  8'h20
`define OFS_BUS_ERR_STS  8'h24
`define OFS_DC_STS       8'h28
`define OFS_REFILL_ADR   8'h2C
`define OFS_REFILL_SYN   8'h30
`define OFS_BACKUP_CACHE_TAG_LATCH       8'h34
`define OFS_INIT_STS     8'h38
`define OFS_PERF_CNT     8'h3C

// ----------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------
`define MEM_CTL_RST      32'h0000_0000
`define BUS_INTERFACE_CONTROL_RST      32'h0000_0000
`define IU_CTL_RST       32'h0000_0000
`define IU_KEEP_MASK     32'h0000_01FF
`define CYC_CTL_RST      32'h0000_0000
`define TLB_PSEL_RST     32'h0000_0000
`define SERIAL_LINE_TRANSMIT_RST      32'h0000_0000
`define WORD_ZERO        32'h0000_0000

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CYC_EN_BIT       0
`define TLB_LARGE_BIT    0
`define SL_PIN_BIT       0
`define STS_FLUSHED_BIT  0
`define STS_BUSLOCK_BIT  1
`define STS_DCLOCK_BIT   2
`define STS_PSEL_BIT     3

`endif

//--- design/ipr_reset_state_pkg.sv
/*
  Shared types of the processor control register bank.
  Assumes: compiled before every design module that names it.
*/
package ipr_reset_state_pkg;

  // ----------------------------------------------------------------------
  // bus types
  // ----------------------------------------------------------------------
  typedef logic [31:0] word_t;   // one register word

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_e;

endpackage

//--- design/reset_sync2.sv
/*
  Two-stage synchroniser for the asynchronous active-low reset.
  Assumes: assertion is asynchronous, release lands on the clock.
*/
`timescale 1ns/1ps
module reset_sync2 (
  input  wire logic i_clk,      // core clock
  input  wire logic i_nrst,     // raw reset, active low
  input  wire logic i_clk_en,   // freeze while low
  output logic      o_nrst      // released copy
);
  // ----------------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------------
  logic meta_n_ff;  // first stage, read only by the second

  // release moves through both stages; assertion is immediate
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_n_ff <= 1'b0;
      o_nrst    <= 1'b0;
    end else if (i_clk_en) begin
      meta_n_ff <= 1'b1;
      o_nrst    <= meta_n_ff;
    end
  end
endmodule

//--- design/error_latch_bank.sv
/*
  Lockable error capture latch: takes one snapshot, then holds it until
  software unlocks it.
  Assumes: capture and unlock come from logic on the same clock.
*/
`timescale 1ns/1ps
module error_latch_bank #(
  parameter int W = 64   // snapshot width
) (
  input  wire logic         i_clk,      // core clock
  input  wire logic         i_nrst,     // synchronised reset, active low
  input  wire logic         i_clk_en,   // freeze while low
  input  wire logic         i_capture,  // error event, one cycle
  input  wire logic [W-1:0] i_data,     // snapshot to take
  input  wire logic         i_unlock,   // software unlock, one cycle
  output logic      [W-1:0] o_data,     // held snapshot
  output logic              o_locked    // snapshot held
);
  // ----------------------------------------------------------------------
  // capture and lock
  // ----------------------------------------------------------------------
  logic take;  // snapshot accepted this cycle

  // a new error in the unlock cycle is taken and relocks
  assign take = i_capture && (!o_locked || i_unlock);

  // lock starts set: content is undefined until unlocked once
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_locked <= 1'b1;
    end else if (i_clk_en) begin
      if (take) begin
        o_locked <= 1'b1;
      end else if (i_unlock) begin
        o_locked <= 1'b0;
      end
    end
  end

  // snapshot has no reset, only a capture loads it
  always_ff @(posedge i_clk) begin
    if (i_clk_en && take) begin
      o_data <= i_data;
    end
  end
endmodule

//--- design/ipr_reset_state_init.sv
/*
  Processor control register bank with its reset state, reached over
  AXI4-Lite.
  Assumes: error and event inputs come from logic on i_core_clk; the bus
  master keeps one write and one read in flight at most.
*/

`timescale 1ns/1ps
`include "ipr_reset_state_init_cfg.svh"
module ipr_reset_state_init #(
  parameter int PERF_W = 16   // width of each performance counter
) (
  input  wire logic        i_core_clk,        // 250 MHz core clock
  input  wire logic        i_nrst,            // async reset, active low
  input  wire logic        i_clk_en,          // freeze all state while low
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // error capture sources and performance events
  input  wire logic        i_bus_err,         // bus error event
  input  wire logic [31:0] i_bus_err_addr,    // failing address
  input  wire logic [31:0] i_bus_err_stat,    // failing status
  input  wire logic        i_fill_err,        // refill error event
  input  wire logic [31:0] i_data_cache_status,         // cache status
  input  wire logic [31:0] i_fill_addr,       // refill address
  input  wire logic [31:0] i_fill_syn,        // refill syndrome
  input  wire logic [31:0] i_backup_cache_tag_latch,          // backup cache tag
  input  wire logic [1:0]  i_perf_event,      // performance events
  // control outputs
  output logic [31:0]      o_memory_unit_control,
  output logic [31:0]      o_bus_interface_control,
  output logic [31:0]      o_instr_unit_control,
  output logic             o_tlb_large_page,  // page size select
  output logic             o_dtlb_flush,      // flush-all pulse
  output logic             o_serial_tx        // serial line pin
);
  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_n;  // synchronised reset

  reset_sync2 u_rst (
    .i_clk    (i_core_clk),
    .i_nrst   (i_nrst),
    .i_clk_en (i_clk_en),
    .o_nrst   (rst_n)
  );

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] dat,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return res;
  endfunction

  // any decoded register
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `OFS_PERF_CNT);
  endfunction

  // registers that accept writes
  function automatic logic is_writable(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `OFS_SERIAL_LINE_TRANSMIT);
  endfunction

  // ----------------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------------
  logic [7:0]  waddr_ff;   // held write address
  logic [31:0] wdata_ff;   // held write data
  logic [3:0]  wstrb_ff;   // held strobes
  logic        aw_hs;      // address taken
  logic        w_hs;       // data taken
  logic        b_hs;       // response taken
  logic        wr_go;      // commit cycle

  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs  = s_axi_wvalid && s_axi_wready;
  assign b_hs  = s_axi_bvalid && s_axi_bready;
  // both halves held and no response pending
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // readiness drops on capture and returns with the response
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ipr_reset_state_pkg::RESP_OKAY;
    end else if (i_clk_en) begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_writable(waddr_ff) ? ipr_reset_state_pkg::RESP_OKAY
                                              : ipr_reset_state_pkg::RESP_SLVERR;
      end else if (b_hs) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // payload holding, no reset needed behind the handshake
  always_ff @(posedge i_core_clk) begin
    if (i_clk_en && aw_hs) begin
      waddr_ff <= s_axi_awaddr;
    end
    if (i_clk_en && w_hs) begin
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
  end

  // write selects
  logic wsel_mem;    // memory unit control
  logic wsel_biu;    // bus interface control
  logic wsel_iu;     // instruction unit control
  logic wsel_cnt;    // cycle count value
  logic wsel_cctl;   // cycle count control
  logic wsel_flush;  // data tlb flush all
  logic wsel_psel;   // tlb page size select
  logic wsel_sl;     // serial line transmit

  assign wsel_mem   = wr_go && (waddr_ff == `OFS_MEM_CTL);
  assign wsel_biu   = wr_go && (waddr_ff == `OFS_BUS_INTERFACE_CONTROL);
  assign wsel_iu    = wr_go && (waddr_ff == `OFS_IU_CTL);
  assign wsel_cnt   = wr_go && (waddr_ff == `OFS_CYC_CNT);
  assign wsel_cctl  = wr_go && (waddr_ff == `OFS_CYC_CTL);
  assign wsel_flush = wr_go && (waddr_ff == `OFS_DTLB_FLUSH);
  assign wsel_psel  = wr_go && (waddr_ff == `OFS_TLB_PSEL);
  assign wsel_sl    = wr_go && (waddr_ff == `OFS_SERIAL_LINE_TRANSMIT);

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  logic [31:0] nxt_mem;   // merged memory control
  logic [31:0] nxt_biu;   // merged bus interface control
  logic [31:0] nxt_iu;    // merged instruction unit control
  logic [31:0] iu_keep_ff;  // address space and counter select, kept
  logic [31:0] iu_clr_ff;   // cleared part
  logic [31:0] cctl_ff;   // cycle count control
  logic [31:0] psel_ff;   // page size select word
  logic [31:0] sl_ff;     // serial transmit word

  assign nxt_mem = merge(o_memory_unit_control, wdata_ff, wstrb_ff);
  assign nxt_biu = merge(o_bus_interface_control, wdata_ff, wstrb_ff);
  assign nxt_iu  = merge(o_instr_unit_control, wdata_ff, wstrb_ff);

  // all zero means write buffer on, every option and cache off
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_memory_unit_control <= `MEM_CTL_RST;
    end else if (i_clk_en && wsel_mem) begin
      o_memory_unit_control <= nxt_mem;
    end
  end

  // all zero: backup cache off, parity mode, timing left for firmware
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_bus_interface_control <= `BUS_INTERFACE_CONTROL_RST;
    end else if (i_clk_en && wsel_biu) begin
      o_bus_interface_control <= nxt_biu;
    end
  end

  // cleared fields: fp off, single issue, pipe on, prediction off
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      iu_clr_ff <= `IU_CTL_RST;
    end else if (i_clk_en && wsel_iu) begin
      iu_clr_ff <= nxt_iu & ~`IU_KEEP_MASK;
    end
  end

  // kept fields survive reset; undefined at power-up
  always_ff @(posedge i_core_clk) begin
    if (i_clk_en && wsel_iu) begin
      iu_keep_ff <= nxt_iu & `IU_KEEP_MASK;
    end
  end

  assign o_instr_unit_control = iu_clr_ff | iu_keep_ff;

  // counter enable starts off; other control bits are scratch
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cctl_ff <= `CYC_CTL_RST;
    end else if (i_clk_en && wsel_cctl) begin
      cctl_ff <= merge(cctl_ff, wdata_ff, wstrb_ff);
    end
  end

  // page size and serial words, pins follow them
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      psel_ff <= `TLB_PSEL_RST;
      sl_ff   <= `SERIAL_LINE_TRANSMIT_RST;
    end else if (i_clk_en) begin
      if (wsel_psel) begin
        psel_ff <= merge(psel_ff, wdata_ff, wstrb_ff);
      end
      if (wsel_sl) begin
        sl_ff <= merge(sl_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  // page size and serial pins registered straight from the words, flush pulse from its write select
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tlb_large_page <= 1'b0;
      o_serial_tx      <= 1'b0;
      o_dtlb_flush     <= 1'b0;
    end else if (i_clk_en) begin
      o_tlb_large_page <= psel_ff[`TLB_LARGE_BIT];
      o_serial_tx      <= sl_ff[`SL_PIN_BIT];
      o_dtlb_flush     <= wsel_flush;
    end
  end

  // ----------------------------------------------------------------------
  // cycle counter
  // ----------------------------------------------------------------------
  logic [31:0] cnt_ff;  // count value, no reset

  // a software load wins over the increment
  always_ff @(posedge i_core_clk) begin
    if (i_clk_en) begin
      if (wsel_cnt) begin
        cnt_ff <= merge(cnt_ff, wdata_ff, wstrb_ff);
      end else if (cctl_ff[`CYC_EN_BIT]) begin
        cnt_ff <= cnt_ff + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // performance counters
  // ----------------------------------------------------------------------
  logic [PERF_W-1:0] perf_ff [2];  // two event counters

  // zeroed by reset, each counts its own event line
  for (genvar k = 0; k < 2; k++) begin : g_perf
    always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
        perf_ff[k] <= '0;
      end else if (i_clk_en && i_perf_event[k]) begin
        perf_ff[k] <= perf_ff[k] + PERF_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // init progress flags
  // ----------------------------------------------------------------------
  logic flushed_ff;  // flush-all written since reset
  logic psel_set_ff; // page size written since reset

  // lets firmware and tests see that flush-all and page size have each been written since reset
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flushed_ff  <= 1'b0;
      psel_set_ff <= 1'b0;
    end else if (i_clk_en) begin
      flushed_ff  <= flushed_ff | wsel_flush;
      psel_set_ff <= psel_set_ff | wsel_psel;
    end
  end

  // ----------------------------------------------------------------------
  // error capture
  // ----------------------------------------------------------------------
  logic        ar_hs;       // read address taken
  logic [63:0] bus_snap;    // address, status
  logic [127:0] dc_snap;    // status, address, syndrome, tag
  logic        bus_locked;  // bus group locked
  logic        dc_locked;   // cache group locked
  logic        unlock_bus;  // status read unlocks
  logic        unlock_dc;   // status read unlocks

  assign ar_hs      = s_axi_arvalid && s_axi_arready;
  assign unlock_bus = ar_hs && (s_axi_araddr == `OFS_BUS_ERR_STS);
  assign unlock_dc  = ar_hs && (s_axi_araddr == `OFS_DC_STS);

  error_latch_bank #(.W(64)) u_bus_err (
    .i_clk     (i_core_clk),
    .i_nrst    (rst_n),
    .i_clk_en  (i_clk_en),
    .i_capture (i_bus_err),
    .i_data    ({i_bus_err_stat, i_bus_err_addr}),
    .i_unlock  (unlock_bus),
    .o_data    (bus_snap),
    .o_locked  (bus_locked)
  );

  error_latch_bank #(.W(128)) u_dc_err (
    .i_clk     (i_core_clk),
    .i_nrst    (rst_n),
    .i_clk_en  (i_clk_en),
    .i_capture (i_fill_err),
    .i_data    ({i_backup_cache_tag_latch, i_fill_syn, i_fill_addr, i_data_cache_status}),
    .i_unlock  (unlock_dc),
    .o_data    (dc_snap),
    .o_locked  (dc_locked)
  );

  // ----------------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------------
  logic [31:0] init_sts;  // progress and lock flags
  logic [31:0] rd_word;   // selected read data
  logic [7:0]  ra;        // read address alias

  assign ra = s_axi_araddr;
  assign init_sts = {28'h000_0000, psel_set_ff, dc_locked, bus_locked, flushed_ff};
  assign rd_word =
    (ra == `OFS_MEM_CTL)     ? o_memory_unit_control :
    (ra == `OFS_BUS_INTERFACE_CONTROL)     ? o_bus_interface_control :
    (ra == `OFS_IU_CTL)      ? o_instr_unit_control :
    (ra == `OFS_CYC_CNT)     ? cnt_ff :
    (ra == `OFS_CYC_CTL)     ? cctl_ff :
    (ra == `OFS_TLB_PSEL)    ? psel_ff :
    (ra == `OFS_SERIAL_LINE_TRANSMIT)     ? sl_ff :
    (ra == `OFS_BUS_ERR_ADR) ? bus_snap[31:0] :
    (ra == `OFS_BUS_ERR_STS) ? bus_snap[63:32] :
    (ra == `OFS_DC_STS)      ? dc_snap[31:0] :
    (ra == `OFS_REFILL_ADR)  ? dc_snap[63:32] :
    (ra == `OFS_REFILL_SYN)  ? dc_snap[95:64] :
    (ra == `OFS_BACKUP_CACHE_TAG_LATCH)      ? dc_snap[127:96] :
    (ra == `OFS_INIT_STS)    ? init_sts :
    (ra == `OFS_PERF_CNT)    ? {perf_ff[1], perf_ff[0]} :
                               `WORD_ZERO;

  // one read in flight; data is sampled on the address edge
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `WORD_ZERO;
      s_axi_rresp   <= ipr_reset_state_pkg::RESP_OKAY;
    end else if (i_clk_en) begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= is_mapped(ra) ? ipr_reset_state_pkg::RESP_OKAY
                                       : ipr_reset_state_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

//--- test/ipr_reset_state_init_asserts.sv
/* reset-state and bus timing checker; bound to the register bank top */
`timescale 1ns/1ps
module ipr_chk (
  input wire logic        i_core_clk, i_nrst, s_axi_awvalid, s_axi_awready,
  input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic        o_dtlb_flush,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] o_memory_unit_control, o_bus_interface_control,
  input wire logic [31:0] o_instr_unit_control
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // -------------------------------------------------------------
  // handshake steps
  // -------------------------------------------------------------
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_answer;
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endsequence
  // internal reset still holds at the release edge, so words must read zero, instruction control only in bits 31:9
  mem_clear_a: assert property ($rose(i_nrst) |-> o_memory_unit_control == 32'h0)
    else $error("memory control not clear");
  biu_clear_a: assert property ($rose(i_nrst) |-> o_bus_interface_control == 32'h0)
    else $error("bus control not clear");
  iu_clear_a: assert property ($rose(i_nrst) |-> o_instr_unit_control[31:9] == 23'h0)
    else $error("instr control not clear");
  flush_pulse_a: assert property (o_dtlb_flush |=> !o_dtlb_flush)
    else $error("flush pulse too long");
  flush_cause_a: assert property (o_dtlb_flush |-> s_axi_bvalid && s_axi_bresp == 2'b00)
    else $error("flush without write");
  wr_latency_a: assert property (wr_taken |=> wr_answer)
    else $error("write answer late");
  b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not released");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule
bind ipr_reset_state_init ipr_chk u_chk (.i_core_clk, .i_nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .o_dtlb_flush, .s_axi_bresp, .o_memory_unit_control,
  .o_bus_interface_control, .o_instr_unit_control);

//--- test/tb.sv
/* self-checking bench for the register bank; drives the bus as master */
`timescale 1ns/1ps
module tb;
  logic i_core_clk, i_nrst, i_clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, i_bus_err, i_fill_err, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, o_tlb_large_page, o_dtlb_flush, o_serial_tx;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, i_perf_event;
  logic [31:0] s_axi_wdata, s_axi_rdata, i_bus_err_addr, i_bus_err_stat, i_data_cache_status, i_fill_addr;
  logic [31:0] i_fill_syn, i_backup_cache_tag_latch, o_memory_unit_control, o_bus_interface_control;
  logic [31:0] o_instr_unit_control;
  int num_errors = 0, checked = 0, flushes = 0;
  ipr_reset_state_init DUT (.i_core_clk, .i_nrst, .i_clk_en, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .i_bus_err, .i_bus_err_addr, .i_bus_err_stat,
    .i_fill_err, .i_data_cache_status, .i_fill_addr, .i_fill_syn, .i_backup_cache_tag_latch, .i_perf_event,
    .o_memory_unit_control, .o_bus_interface_control, .o_instr_unit_control,
    .o_tlb_large_page, .o_dtlb_flush, .o_serial_tx);
  initial begin
    i_core_clk = 0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  // sampled mid-cycle so the pulse is settled
  always @(negedge i_core_clk) if (o_dtlb_flush === 1'b1) flushes++;
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // readies are looked at mid-cycle, valids dropped after the edge that took them
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ta, tw, tr;
    logic [1:0] rs;
    @(posedge i_core_clk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    do begin
      @(negedge i_core_clk);
      {ta, tw, tr, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge i_core_clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end while (!tr);
    s_axi_bready <= 0;
    chk("bresp", er, rs);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] v;
    logic [1:0] rs;
    @(posedge i_core_clk);
    {s_axi_arvalid, s_axi_rready, s_axi_araddr} <= {2'h3, a};
    do begin
      @(negedge i_core_clk);
      {ta, tr, v, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge i_core_clk);
      if (ta) s_axi_arvalid <= 0;
    end while (!tr);
    s_axi_rready <= 0;
    chk("rdata", e, v & m);
    chk("rresp", er, rs);
  endtask
  task automatic pulse(input logic b, input logic [31:0] d);
    {i_bus_err, i_fill_err, i_bus_err_addr, i_backup_cache_tag_latch} <= {b, !b, d, d};
    @(posedge i_core_clk);
    {i_bus_err, i_fill_err} <= 2'h0;
    @(posedge i_core_clk);
  endtask
  initial begin
    #80000;
    num_errors++;
    stop_test;
  end
  initial begin
    {i_nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {i_bus_err, i_fill_err, i_perf_event, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 0;
    {s_axi_wdata, i_bus_err_addr, i_bus_err_stat, i_data_cache_status, i_fill_addr, i_fill_syn} = 0;
    {i_clk_en, i_backup_cache_tag_latch} = {1'b1, 32'h0};
    repeat (10) @(posedge i_core_clk);
    i_nrst <= 1;
    repeat (3) @(posedge i_core_clk);
    chk("mem_ctl", 32'h0, o_memory_unit_control);
    chk("bus_interface_control", 32'h0, o_bus_interface_control);
    chk("iu_ctl", 32'h0, o_instr_unit_control & 32'hFFFF_FE00);
    rd(8'h10, 32'h0, '1, 2'h0);
    rd(8'h38, 32'h6, '1, 2'h0);
    wr(8'h0C, 32'h5, 4'hF, 2'h0);
    rd(8'h0C, 32'h5, '1, 2'h0);
    wr(8'h10, 32'h1, 4'hF, 2'h0);
    wr(8'h0C, 32'h0, 4'hF, 2'h0);
    rd(8'h0C, 32'h2, '1, 2'h0);
    $display("test reset state done");
    wr(8'h14, 32'h1, 4'hF, 2'h0);
    rd(8'h14, 32'h0, '1, 2'h0);
    chk("flushes", 32'h1, flushes);
    wr(8'h18, 32'h1, 4'hF, 2'h0);
    wr(8'h1C, 32'h1, 4'hF, 2'h0);
    @(negedge i_core_clk);
    chk("large_page", 32'h1, o_tlb_large_page);
    chk("serial_tx", 32'h1, o_serial_tx);
    rd(8'h38, 32'hF, '1, 2'h0);
    wr(8'h00, 32'h1234_5678, 4'hF, 2'h0);
    wr(8'h00, 32'hFFFF_FFFF, 4'h2, 2'h0);
    rd(8'h00, 32'h1234_FF78, '1, 2'h0);
    wr(8'h04, 32'hA5A5_5A5A, 4'hF, 2'h0);
    rd(8'h04, 32'hA5A5_5A5A, '1, 2'h0);
    wr(8'h08, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd(8'h08, 32'hFFFF_FFFF, '1, 2'h0);
    wr(8'h20, 32'h1, 4'hF, 2'h2);
    rd(8'h40, 32'h0, '1, 2'h2);
    rd(8'h02, 32'h0, '1, 2'h2);
    $display("test writes done");
    rd(8'h24, 32'h0, 32'h0, 2'h0);
    pulse(1'b1, 32'hDEAD_0001);
    pulse(1'b1, 32'h0000_0777);
    rd(8'h20, 32'hDEAD_0001, '1, 2'h0);
    rd(8'h28, 32'h0, 32'h0, 2'h0);
    pulse(1'b0, 32'h0000_BEEF);
    rd(8'h34, 32'h0000_BEEF, '1, 2'h0);
    i_perf_event <= 2'h3;
    repeat (5) @(posedge i_core_clk);
    i_perf_event <= 2'h0;
    rd(8'h3C, 32'h0005_0005, '1, 2'h0);
    $display("test capture done");
    i_nrst <= 0;
    repeat (2) @(posedge i_core_clk);
    i_nrst <= 1;
    repeat (3) @(posedge i_core_clk);
    chk("mem_ctl", 32'h0, o_memory_unit_control);
    chk("bus_interface_control", 32'h0, o_bus_interface_control);
    chk("serial_tx", 32'h0, o_serial_tx);
    chk("iu_ctl", 32'h1FF, o_instr_unit_control);
    rd(8'h10, 32'h0, '1, 2'h0);
    rd(8'h3C, 32'h0, '1, 2'h0);
    $display("test second reset done");
    stop_test;
  end
endmodule
